//--- logic/ihl_pkg.sv
// package: layout, offsets and types of the core error header logs
`default_nettype none

package ihl_pkg;

   // ----------------------------------------------------------------
   // configuration space offsets (byte addresses, 12-bit space)
   // ----------------------------------------------------------------
   localparam logic [11:0] CFG_FATAL_HDR_OFS    = 12'h30c;
   localparam logic [11:0] CFG_NONFATAL_HDR_OFS = 12'h324;
   localparam int          CFG_ADDR_W           = 12;
   localparam int          CFG_DATA_W           = 32;
   localparam int          LOG_WORDS            = 4;

   // ----------------------------------------------------------------
   // log field layout
   // ----------------------------------------------------------------
   localparam int LOG_W          = 128;
   localparam int LOG_RSV_LSB    = 90;
   localparam int LOG_TYPE_BIT   = 89;
   localparam int LOG_MSG_LSB    = 81;
   localparam int LOG_MSI_LSB    = 65;
   localparam int LOG_ROUTE_LSB  = 58;
   localparam int LOG_FT_LSB     = 51;
   localparam int LOG_ADDR_W     = 51;
   localparam int LOG_DEST_LSB   = 21;
   localparam int LOG_HINT_BIT   = 20;
   localparam int LOG_MODE_BIT   = 19;
   localparam int LOG_DEST_W     = 30;
   localparam logic [LOG_W-1:0] LOG_RESET = 128'h0;

   // error type encoding
   localparam logic MASTER_ABORT_TYPE    = 1'h0;
   localparam logic COMPLETER_ABORT_TYPE = 1'h1;

   // ----------------------------------------------------------------
   // switch route id upper nibbles and lower code limits
   // ----------------------------------------------------------------
   localparam logic [3:0] ROUTE_PCIE_X16    = 4'h0;
   localparam logic [3:0] ROUTE_PLATFORM    = 4'h2;
   localparam logic [3:0] ROUTE_DMA         = 4'h3;
   localparam logic [3:0] ROUTE_MISC        = 4'h5;
   localparam logic [3:0] ROUTE_COHERENT    = 4'h6;
   localparam logic [2:0] PCIE_LAST_CODE    = 3'h3;
   localparam logic [2:0] PCIE_FIRST_DEVICE = 3'h3;
   localparam logic [2:0] DMA_LAST_CODE     = 3'h2;
   localparam logic [2:0] COHERENT_CODE     = 3'h0;

   typedef enum logic [2:0] {
      IHL_SRC_NONE,
      IHL_SRC_PCIE_X16,
      IHL_SRC_PLATFORM_HUB,
      IHL_SRC_DMA_ENGINE,
      IHL_SRC_MISC,
      IHL_SRC_COHERENT_LINK,
      IHL_SRC_RESERVED
   } ihl_src_t;

   typedef struct packed {
      ihl_src_t   cls;
      logic [2:0] unit;    // port device number for pcie, else lower code
      logic       legal;   // lower code is a defined one for the class
   } ihl_src_info_t;

   // datapath header of a failing transaction
   typedef struct packed {
      logic        err_type;
      logic [7:0]  msg_code;
      logic [15:0] msi_data;
      logic [6:0]  switch_route_id;
      logic [1:0]  fmt;
      logic [4:0]  pkt_type;
      logic [50:0] addr;
      logic        is_intr;
      logic        remap_en;
      logic [31:0] dest_id;
      logic        redirect_hint;
      logic        dest_mode;
   } ihl_err_hdr_t;

endpackage

`default_nettype wire

//--- logic/ihl_hdr_capture.sv
// one sticky header log: formats and holds the captured header
`default_nettype none

module ihl_hdr_capture #(
   parameter bit REMAP_FMT = 1'h1
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_por_rstn,
   input  wire logic                      i_take,
   input  wire logic                      i_clear,
   input  wire ihl_pkg::ihl_err_hdr_t     i_hdr,
   output logic [ihl_pkg::LOG_W-1:0]      o_log,
   output logic                           o_held
);

   // ----------------------------------------------------------------
   // header formatting
   // ----------------------------------------------------------------
   logic [ihl_pkg::LOG_W-1:0] log_next;

   always_comb begin
      log_next = ihl_pkg::LOG_RESET;
      log_next[ihl_pkg::LOG_TYPE_BIT] = i_hdr.err_type;
      log_next[ihl_pkg::LOG_MSG_LSB +: 8] = i_hdr.msg_code;
      log_next[ihl_pkg::LOG_MSI_LSB +: 16] = i_hdr.msi_data;
      log_next[ihl_pkg::LOG_ROUTE_LSB +: 7] = i_hdr.switch_route_id;
      log_next[ihl_pkg::LOG_FT_LSB +: 7] = {i_hdr.fmt, i_hdr.pkt_type};
      if (REMAP_FMT && i_hdr.is_intr && i_hdr.remap_en) begin
         // dest bits 31:30 are dropped; low address bits logged as zero
         log_next[ihl_pkg::LOG_DEST_LSB +: ihl_pkg::LOG_DEST_W] =
            i_hdr.dest_id[ihl_pkg::LOG_DEST_W-1:0];
         log_next[ihl_pkg::LOG_HINT_BIT] = i_hdr.redirect_hint;
         log_next[ihl_pkg::LOG_MODE_BIT] = i_hdr.dest_mode;
      end else begin
         log_next[ihl_pkg::LOG_ADDR_W-1:0] = i_hdr.addr;
      end
   end

   // ----------------------------------------------------------------
   // sticky storage, only the power-on reset clears the log; i_clear also clears the held flag
   // ----------------------------------------------------------------
   logic [ihl_pkg::LOG_W-1:0] log_reg;
   logic                      held_reg;

   always_ff @(posedge i_clk or negedge i_por_rstn) begin
      if (!i_por_rstn) begin
         log_reg <= ihl_pkg::LOG_RESET;
      end else if (i_take) begin
         log_reg <= log_next;
      end
   end

   // a new first error in the clear cycle wins over the clear
   always_ff @(posedge i_clk or negedge i_por_rstn) begin
      if (!i_por_rstn) begin
         held_reg <= 1'h0;
      end else if (i_take) begin
         held_reg <= 1'h1;
      end else if (i_clear) begin
         held_reg <= 1'h0;
      end
   end

   assign o_log  = log_reg;
   assign o_held = held_reg;

endmodule

`default_nettype wire

//--- logic/ihl_error_header_log.sv
// core fatal / non-fatal first error header logs with config read port
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`default_nettype none

module ihl_error_header_log (
   input  wire logic                             i_clk,
   input  wire logic                             i_rstn,
   input  wire logic                             i_por_rstn,
   input  wire logic                             i_err_valid,
   input  wire logic                             i_err_fatal,
   input  wire ihl_pkg::ihl_err_hdr_t            i_err_hdr,
   input  wire logic                             i_fatal_first_clr,
   input  wire logic                             i_nonfatal_first_clr,
   input  wire logic                             i_cfg_req,
   input  wire logic                             i_cfg_wr,
   input  wire logic [ihl_pkg::CFG_ADDR_W-1:0]   i_cfg_addr,
   output logic                                  o_cfg_ack,
   output logic [ihl_pkg::CFG_DATA_W-1:0]        o_cfg_rdata,
   output logic                                  o_fatal_held,
   output logic                                  o_nonfatal_held,
   output ihl_pkg::ihl_src_info_t                o_fatal_src,
   output ihl_pkg::ihl_src_info_t                o_nonfatal_src
);

   // ------------------------------------------------------------------
   // per-class capture (index 0 fatal, index 1 non-fatal)
   // ------------------------------------------------------------------
   localparam int NCLS = 2;

   logic [NCLS-1:0]               cls_hit;
   logic [NCLS-1:0]               cls_clr;
   logic [NCLS-1:0]               cls_take;
   logic [NCLS-1:0]               cls_held;
   logic [ihl_pkg::LOG_W-1:0]     cls_log [NCLS];

   assign cls_hit[0] = i_err_valid && i_err_fatal;
   assign cls_hit[1] = i_err_valid && !i_err_fatal;
   assign cls_clr[0] = i_fatal_first_clr;
   assign cls_clr[1] = i_nonfatal_first_clr;

   genvar g;
   generate
      for (g = 0; g < NCLS; g++) begin : g_cls
         // later errors of the class are dropped while one is held, except in a cycle with the class clear
         assign cls_take[g] = cls_hit[g] &&
            (!cls_held[g] || cls_clr[g]);

         ihl_hdr_capture #(
            .REMAP_FMT (g == 0)
         ) u_cap (
            .i_clk      (i_clk),
            .i_por_rstn (i_por_rstn),
            .i_take     (cls_take[g]),
            .i_clear    (cls_clr[g]),
            .i_hdr      (i_err_hdr),
            .o_log      (cls_log[g]),
            .o_held     (cls_held[g])
         );
      end
   endgenerate

   assign o_fatal_held    = cls_held[0];
   assign o_nonfatal_held = cls_held[1];

   // ------------------------------------------------------------------
   // configuration read decode
   // ------------------------------------------------------------------
   localparam int DW_W = ihl_pkg::CFG_ADDR_W - 2;
   localparam logic [DW_W-1:0] FATAL_DW =
      ihl_pkg::CFG_FATAL_HDR_OFS[ihl_pkg::CFG_ADDR_W-1:2];
   localparam logic [DW_W-1:0] NONFATAL_DW =
      ihl_pkg::CFG_NONFATAL_HDR_OFS[ihl_pkg::CFG_ADDR_W-1:2];
   localparam logic [DW_W-1:0] NWORDS = DW_W'(ihl_pkg::LOG_WORDS);

   logic [DW_W-1:0]                 req_dw;
   logic [DW_W-1:0]                 fatal_idx;
   logic [DW_W-1:0]                 nonfatal_idx;
   logic [ihl_pkg::CFG_DATA_W-1:0]  rdata_next;

   assign req_dw       = i_cfg_addr[ihl_pkg::CFG_ADDR_W-1:2];
   assign fatal_idx    = req_dw - FATAL_DW;
   assign nonfatal_idx = req_dw - NONFATAL_DW;

   // logs are read only: writes are acknowledged and dropped
   always_comb begin
      rdata_next = '0;
      if (fatal_idx < NWORDS) begin
         rdata_next = cls_log[0][fatal_idx[1:0]*32 +: 32];
      end else if (nonfatal_idx < NWORDS) begin
         rdata_next = cls_log[1][nonfatal_idx[1:0]*32 +: 32];
      end
   end

   logic                           ack_reg;
   logic [ihl_pkg::CFG_DATA_W-1:0] rdata_reg;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ack_reg <= 1'h0;
      end else begin
         ack_reg <= i_cfg_req;
      end
   end

   // unmapped offsets and writes read back zero
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_reg <= '0;
      end else if (i_cfg_req) begin
         rdata_reg <= i_cfg_wr ? '0 : rdata_next;
      end
   end

   assign o_cfg_ack   = ack_reg;
   assign o_cfg_rdata = rdata_reg;

   // ------------------------------------------------------------------
   // switch route id decode of the held headers
   // ------------------------------------------------------------------
   function automatic ihl_pkg::ihl_src_info_t decode_route(
      input logic [6:0] id
   );
      ihl_pkg::ihl_src_info_t info;
      info.cls   = ihl_pkg::IHL_SRC_RESERVED;
      info.unit  = id[2:0];
      info.legal = 1'h0;
      unique case (id[6:3])
         ihl_pkg::ROUTE_PCIE_X16: begin
            info.cls   = ihl_pkg::IHL_SRC_PCIE_X16;
            info.unit  = id[2:0] + ihl_pkg::PCIE_FIRST_DEVICE;
            info.legal = id[2:0] <= ihl_pkg::PCIE_LAST_CODE;
         end
         ihl_pkg::ROUTE_PLATFORM: begin
            info.cls   = ihl_pkg::IHL_SRC_PLATFORM_HUB;
            info.legal = 1'h1;
         end
         ihl_pkg::ROUTE_DMA: begin
            info.cls   = ihl_pkg::IHL_SRC_DMA_ENGINE;
            info.legal = id[2:0] <= ihl_pkg::DMA_LAST_CODE;
         end
         ihl_pkg::ROUTE_MISC: begin
            info.cls   = ihl_pkg::IHL_SRC_MISC;
            info.legal = 1'h1;
         end
         ihl_pkg::ROUTE_COHERENT: begin
            info.cls   = ihl_pkg::IHL_SRC_COHERENT_LINK;
            info.legal = id[2:0] == ihl_pkg::COHERENT_CODE;
         end
         default: begin
            // nibbles 0001, 0100, 0111..1111 carry no lower code
            info.cls   = ihl_pkg::IHL_SRC_RESERVED;
            info.legal = 1'h0;
         end
      endcase
      return info;
   endfunction

   ihl_pkg::ihl_src_info_t src_reg [NCLS];

   generate
      for (g = 0; g < NCLS; g++) begin : g_src
         // one cycle behind the log; none while nothing is held
         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               src_reg[g] <= '{ihl_pkg::IHL_SRC_NONE, 3'h0, 1'h0};
            end else if (cls_held[g]) begin
               src_reg[g] <= decode_route(
                  cls_log[g][ihl_pkg::LOG_ROUTE_LSB +: 7]);
            end else begin
               src_reg[g] <= '{ihl_pkg::IHL_SRC_NONE, 3'h0, 1'h0};
            end
         end
      end
   endgenerate

   assign o_fatal_src    = src_reg[0];
   assign o_nonfatal_src = src_reg[1];

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn || !i_por_rstn);

   logic [ihl_pkg::LOG_W-1:0] flog;
   logic [ihl_pkg::LOG_W-1:0] nlog;
   assign flog = cls_log[0];
   assign nlog = cls_log[1];

   sequence s_fatal_first;
      i_err_valid && i_err_fatal && !cls_held[0] && !i_fatal_first_clr;
   endsequence

   sequence s_fatal_rd(int w);
      i_cfg_req && !i_cfg_wr &&
         (req_dw == FATAL_DW + DW_W'(w));
   endsequence

   property p_rd_fatal_w0;
      s_fatal_rd(0) |=> o_cfg_ack && (o_cfg_rdata == $past(flog[31:0]));
   endproperty
   a_rd_fatal_w0: assert property (p_rd_fatal_w0)
      else $error("fatal log word 0 read mismatch");

   property p_rd_nonfatal_w3;
      (i_cfg_req && !i_cfg_wr && req_dw == NONFATAL_DW + 10'h3)
         |=> o_cfg_ack && (o_cfg_rdata == $past(nlog[127:96]));
   endproperty
   a_rd_nonfatal_w3: assert property (p_rd_nonfatal_w3)
      else $error("non-fatal log top word read mismatch");

   property p_rsv_zero;
      flog[127:90] == '0 && nlog[127:90] == '0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("reserved log bits not zero");

   property p_type_bit;
      s_fatal_first |=> flog[89] == $past(i_err_hdr.err_type);
   endproperty
   a_type_bit: assert property (p_type_bit)
      else $error("error type bit not captured");

   property p_msg_msi;
      s_fatal_first |=> flog[88:81] == $past(i_err_hdr.msg_code) &&
         flog[80:65] == $past(i_err_hdr.msi_data);
   endproperty
   a_msg_msi: assert property (p_msg_msi)
      else $error("message code or msi data not captured");

   property p_route_ft;
      s_fatal_first |=>
         flog[64:58] == $past(i_err_hdr.switch_route_id) &&
         flog[57:51] == $past({i_err_hdr.fmt, i_err_hdr.pkt_type});
   endproperty
   a_route_ft: assert property (p_route_ft)
      else $error("route id or format/type not captured");

   property p_remap;
      s_fatal_first ##0 (i_err_hdr.is_intr && i_err_hdr.remap_en) |=>
         flog[50:21] == $past(i_err_hdr.dest_id[29:0]) &&
         flog[20] == $past(i_err_hdr.redirect_hint) &&
         flog[19] == $past(i_err_hdr.dest_mode) && flog[18:0] == '0;
   endproperty
   a_remap: assert property (p_remap)
      else $error("remapped interrupt address not formatted");

   property p_hold;
      (cls_held[0] && !i_fatal_first_clr) |=> $stable(flog) && cls_held[0];
   endproperty
   a_hold: assert property (p_hold)
      else $error("fatal log changed while held");

   property p_set_wins;
      (i_err_valid && !i_err_fatal && i_nonfatal_first_clr) |=>
         cls_held[1] && nlog[88:81] == $past(i_err_hdr.msg_code);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("error in clear cycle lost");

   property p_wr_ro;
      (i_cfg_req && i_cfg_wr && !i_err_valid) |=>
         $stable(flog) && $stable(nlog) && o_cfg_rdata == '0;
   endproperty
   a_wr_ro: assert property (p_wr_ro)
      else $error("write altered a read-only log");

   property p_src_decode;
      (cls_held[0] && flog[64:61] == ihl_pkg::ROUTE_PCIE_X16 &&
         cls_held[0] ##1 cls_held[0] && $stable(flog)) |->
         o_fatal_src.cls == ihl_pkg::IHL_SRC_PCIE_X16 &&
         o_fatal_src.unit == 3'(flog[60:58] + 3'h3);
   endproperty
   a_src_decode: assert property (p_src_decode)
      else $error("x16 route id decoded wrongly");

   property p_src_rsv;
      (cls_held[1] && nlog[64:61] >= 4'h7) |=>
         o_nonfatal_src.cls == ihl_pkg::IHL_SRC_RESERVED &&
         !o_nonfatal_src.legal;
   endproperty
   a_src_rsv: assert property (p_src_rsv)
      else $error("reserved route nibble not flagged");

endmodule

`default_nettype wire

//--- test/ihl_tb.sv
// testbench: core error header logs checked against a bench model
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // signals and model state
   // ----------------------------------------------------------------
   logic                           i_clk;
   logic                           i_rstn;
   logic                           i_por_rstn;
   logic                           i_err_valid;
   logic                           i_err_fatal;
   ihl_pkg::ihl_err_hdr_t          i_err_hdr;
   logic                           i_fatal_first_clr;
   logic                           i_nonfatal_first_clr;
   logic                           i_cfg_req;
   logic                           i_cfg_wr;
   logic [ihl_pkg::CFG_ADDR_W-1:0] i_cfg_addr;
   logic                           o_cfg_ack;
   logic [ihl_pkg::CFG_DATA_W-1:0] o_cfg_rdata;
   logic                           o_fatal_held;
   logic                           o_nonfatal_held;
   ihl_pkg::ihl_src_info_t         o_fatal_src;
   ihl_pkg::ihl_src_info_t         o_nonfatal_src;
   int                             failures;
   int                             n_checks;
   int                             seed;
   logic [127:0]                   mlog [2];
   logic                           mheld [2];

   ihl_error_header_log ihl_error_header_log_i (
      .i_clk                (i_clk),
      .i_rstn               (i_rstn),
      .i_por_rstn           (i_por_rstn),
      .i_err_valid          (i_err_valid),
      .i_err_fatal          (i_err_fatal),
      .i_err_hdr            (i_err_hdr),
      .i_fatal_first_clr    (i_fatal_first_clr),
      .i_nonfatal_first_clr (i_nonfatal_first_clr),
      .i_cfg_req            (i_cfg_req),
      .i_cfg_wr             (i_cfg_wr),
      .i_cfg_addr           (i_cfg_addr),
      .o_cfg_ack            (o_cfg_ack),
      .o_cfg_rdata          (o_cfg_rdata),
      .o_fatal_held         (o_fatal_held),
      .o_nonfatal_held      (o_nonfatal_held),
      .o_fatal_src          (o_fatal_src),
      .o_nonfatal_src       (o_nonfatal_src)
   );

   initial begin
      i_clk = 1'h0;
      forever #12.5 i_clk = ~i_clk;
   end

   // ----------------------------------------------------------------
   // model and helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [127:0] seen,
                        input logic [127:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [127:0] fmt_log(input ihl_pkg::ihl_err_hdr_t h,
                                            input logic fatal);
      logic [127:0] l;
      l = '0;
      l[89] = h.err_type;
      l[88:81] = h.msg_code;
      l[80:65] = h.msi_data;
      l[64:58] = h.switch_route_id;
      l[57:51] = {h.fmt, h.pkt_type};
      if (fatal && h.is_intr && h.remap_en)
         l[50:0] = {h.dest_id[29:0], h.redirect_hint, h.dest_mode, 19'h0};
      else
         l[50:0] = h.addr;
      return l;
   endfunction

   function automatic ihl_pkg::ihl_src_info_t exp_src(input logic [6:0] r,
                                                      input logic held);
      ihl_pkg::ihl_src_info_t s;
      s.cls = held ? ihl_pkg::IHL_SRC_RESERVED : ihl_pkg::IHL_SRC_NONE;
      s.unit = held ? r[2:0] : 3'h0;
      s.legal = 1'h0;
      if (held) begin
         case (r[6:3])
            4'h0: begin
               s.cls = ihl_pkg::IHL_SRC_PCIE_X16;
               s.unit = r[2:0] + 3'h3;
               s.legal = (r[2:0] <= 3'h3);
            end
            4'h2: begin
               s.cls = ihl_pkg::IHL_SRC_PLATFORM_HUB;
               s.legal = 1'h1;
            end
            4'h3: begin
               s.cls = ihl_pkg::IHL_SRC_DMA_ENGINE;
               s.legal = (r[2:0] <= 3'h2);
            end
            4'h5: begin
               s.cls = ihl_pkg::IHL_SRC_MISC;
               s.legal = 1'h1;
            end
            4'h6: begin
               s.cls = ihl_pkg::IHL_SRC_COHERENT_LINK;
               s.legal = (r[2:0] == 3'h0);
            end
            default: ;
         endcase
      end
      return s;
   endfunction

   function automatic ihl_pkg::ihl_err_hdr_t rand_hdr();
      logic [127:0] r;
      r = {$random(seed), $random(seed), $random(seed), $random(seed)};
      return r[$bits(ihl_pkg::ihl_err_hdr_t)-1:0];
   endfunction

   task automatic inject(input logic fatal, input ihl_pkg::ihl_err_hdr_t h,
                         input logic clr);
      @(posedge i_clk);
      i_err_valid <= 1'h1;
      i_err_fatal <= fatal;
      i_err_hdr <= h;
      i_fatal_first_clr <= clr & fatal;
      i_nonfatal_first_clr <= clr & ~fatal;
      @(posedge i_clk);
      i_err_valid <= 1'h0;
      i_fatal_first_clr <= 1'h0;
      i_nonfatal_first_clr <= 1'h0;
      // an error in the clear cycle wins over the clear
      if (!mheld[fatal] || clr) begin
         mlog[fatal] = fmt_log(h, fatal);
         mheld[fatal] = 1'h1;
      end
   endtask

   task automatic clear(input logic fatal);
      @(posedge i_clk);
      i_fatal_first_clr <= fatal;
      i_nonfatal_first_clr <= ~fatal;
      @(posedge i_clk);
      i_fatal_first_clr <= 1'h0;
      i_nonfatal_first_clr <= 1'h0;
      mheld[fatal] = 1'h0;
   endtask

   task automatic cfg(input logic wr, input logic [11:0] a,
                      output logic [31:0] d);
      @(posedge i_clk);
      i_cfg_req <= 1'h1;
      i_cfg_wr <= wr;
      i_cfg_addr <= a;
      @(posedge i_clk);
      i_cfg_req <= 1'h0;
      #1;
      check("cfg ack", {127'h0, o_cfg_ack}, 128'h1);
      d = o_cfg_rdata;
   endtask

   // reads all four dwords, then held flag and decoded source
   task automatic check_log(input logic fatal);
      logic [31:0]            d;
      logic [11:0]            base;
      logic                   hv;
      ihl_pkg::ihl_src_info_t s;
      ihl_pkg::ihl_src_info_t e;
      base = fatal ? 12'h30c : 12'h324;
      for (int w = 0; w < 4; w++) begin
         cfg(1'h0, base + 12'(4 * w), d);
         check("dword", {96'h0, d}, {96'h0, mlog[fatal][32*w +: 32]});
      end
      hv = fatal ? o_fatal_held : o_nonfatal_held;
      check("held", {127'h0, hv}, {127'h0, mheld[fatal]});
      s = fatal ? o_fatal_src : o_nonfatal_src;
      e = exp_src(mlog[fatal][64:58], mheld[fatal]);
      // unit has no meaning for an undefined lower code
      if (mheld[fatal] && !e.legal) begin
         s.unit = 3'h0;
         e.unit = 3'h0;
      end
      check("source", {121'h0, s}, {121'h0, e});
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      #(25ns * 40000);
      failures++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0]           d;
      ihl_pkg::ihl_err_hdr_t h;
      seed = 32'h689b;
      failures = 0;
      n_checks = 0;
      i_rstn = 1'h0;
      i_por_rstn = 1'h0;
      i_err_valid = 1'h0;
      i_err_fatal = 1'h0;
      i_err_hdr = '0;
      i_fatal_first_clr = 1'h0;
      i_nonfatal_first_clr = 1'h0;
      i_cfg_req = 1'h0;
      i_cfg_wr = 1'h0;
      i_cfg_addr = 12'h0;
      mlog[0] = '0;
      mlog[1] = '0;
      mheld[0] = 1'h0;
      mheld[1] = 1'h0;
      repeat (10) @(posedge i_clk);
      i_rstn <= 1'h1;
      i_por_rstn <= 1'h1;
      check_log(1'h0);
      check_log(1'h1);
      // remapped interrupt with destination top bits set
      h = rand_hdr();
      h.is_intr = 1'h1;
      h.remap_en = 1'h1;
      h.dest_id[31:30] = 2'h3;
      inject(1'h1, h, 1'h0);
      inject(1'h0, h, 1'h0);
      repeat (2) @(posedge i_clk);
      check_log(1'h1);
      check_log(1'h0);
      // writes and unmapped reads return zero and change nothing
      cfg(1'h1, 12'h30c, d);
      check("write data", {96'h0, d}, 128'h0);
      cfg(1'h0, 12'h200, d);
      check("unmapped", {96'h0, d}, 128'h0);
      inject(1'h1, rand_hdr(), 1'h0);
      check_log(1'h1);
      // functional reset alone keeps the sticky logs
      @(posedge i_clk);
      i_rstn <= 1'h0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'h1;
      repeat (2) @(posedge i_clk);
      check_log(1'h1);
      clear(1'h1);
      repeat (2) @(posedge i_clk);
      check_log(1'h1);
      inject(1'h0, rand_hdr(), 1'h1);
      repeat (2) @(posedge i_clk);
      check_log(1'h0);
      // every route id, both classes, both error types
      for (int i = 0; i < 256; i++) begin
         clear(i[7]);
         h = rand_hdr();
         h.switch_route_id = i[6:0];
         h.err_type = i[1];
         inject(i[7], h, 1'h0);
         repeat (2) @(posedge i_clk);
         check_log(i[7]);
      end
      // power-on reset clears both logs
      @(posedge i_clk);
      i_por_rstn <= 1'h0;
      repeat (2) @(posedge i_clk);
      i_por_rstn <= 1'h1;
      mlog[0] = '0;
      mlog[1] = '0;
      mheld[0] = 1'h0;
      mheld[1] = 1'h0;
      repeat (2) @(posedge i_clk);
      check_log(1'h0);
      check_log(1'h1);
      stop_test();
   end

endmodule

`default_nettype wire
